// ### logic/usb_xcvr_ctrl.sv
// Transceiver control register, line drive and endpoint map
`timescale 1ns/10ps
`default_nettype none
module usb_xcvr_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Processor register port
  input wire xcvr_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // Serial engine side
  input wire xcvr_pkg::sie_tx_t sie_tx,
  input wire logic token_valid,
  input wire logic token_in,
  input wire logic [7:0] token_addr,
  output xcvr_pkg::ep_sel_t ep_sel,
  output logic rx_diff,
  output logic rx_dp,
  output logic rx_dm,
  output logic full_speed,
  output logic xcvr_suspend,
  // Bus power
  input wire logic vbus_present,
  // D+ and D- pins
  input wire logic dp_in,
  output logic dp_out,
  output logic dp_oe,
  input wire logic dm_in,
  output logic dm_out,
  output logic dm_oe,
  // Pullup switches
  output logic pullup_dp_en,
  output logic pullup_dm_en
);
  import xcvr_pkg::*;

  typedef struct packed {
    xcvr_ctrl_t ctrl;
    logic [7:0] rdata;
    logic diff;
    logic dp_lvl;
    logic dm_lvl;
    logic dp_drv;
    logic dm_drv;
    logic drive;
    logic pu_dp;
    logic pu_dm;
  } xs_state_t;

  xs_state_t s_q;
  xs_state_t s_d;
  logic ctrl_hit;
  logic [7:0] reg_view;
  logic tok_gated;

  assign ctrl_hit = sfr_req.addr == XCVR_CTRL_ADDR;

  // Register image as software reads it
  always_comb begin
    reg_view = 8'h00;
    reg_view[PULLUP_EN_BIT] = s_q.ctrl.pullup_enable;
    reg_view[XCVR_EN_BIT] = s_q.ctrl.transceiver_enable;
    reg_view[SPEED_BIT] = s_q.ctrl.full_speed;
    reg_view[TEST_HI_BIT:TEST_LO_BIT] = s_q.ctrl.line_test_select;
    reg_view[DIFF_RX_BIT] = s_q.diff;
    reg_view[DPLUS_BIT] = s_q.dp_lvl;
    reg_view[DMINUS_BIT] = s_q.dm_lvl;
  end

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    if (sfr_req.wr && ctrl_hit) begin
      s_d.ctrl.pullup_enable = sfr_req.wdata[PULLUP_EN_BIT];
      s_d.ctrl.transceiver_enable = sfr_req.wdata[XCVR_EN_BIT];
      s_d.ctrl.full_speed = sfr_req.wdata[SPEED_BIT];
      s_d.ctrl.line_test_select = sfr_req.wdata[TEST_HI_BIT:TEST_LO_BIT];
    end
    // Read data latched on a hit, zero elsewhere
    if (sfr_req.rd) begin
      s_d.rdata = ctrl_hit ? reg_view : 8'h00;
    end
    // pin levels always, receiver only while enabled
    s_d.dp_lvl = dp_in;
    s_d.dm_lvl = dm_in;
    s_d.diff = s_q.ctrl.transceiver_enable & dp_in & ~dm_in;
    // drive only for the engine's answers while enabled
    s_d.drive = s_q.ctrl.transceiver_enable & sie_tx.en;
    s_d.dp_drv = sie_tx.dp;
    s_d.dm_drv = sie_tx.dm;
    // forced line states override the engine
    if (s_q.ctrl.transceiver_enable) begin
      unique case (s_q.ctrl.line_test_select)
        TEST_NORMAL: begin
        end
        TEST_DIFF_ONE: begin
          s_d.drive = 1'b1;
          s_d.dp_drv = 1'b1;
          s_d.dm_drv = 1'b0;
        end
        TEST_DIFF_ZERO: begin
          s_d.drive = 1'b1;
          s_d.dp_drv = 1'b0;
          s_d.dm_drv = 1'b1;
        end
        TEST_SE_ZERO: begin
          s_d.drive = 1'b1;
          s_d.dp_drv = 1'b0;
          s_d.dm_drv = 1'b0;
        end
      endcase
    end
    s_d.pu_dp = s_q.ctrl.pullup_enable & vbus_present & s_q.ctrl.full_speed;
    s_d.pu_dm = s_q.ctrl.pullup_enable & vbus_present & ~s_q.ctrl.full_speed;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Tokens decode only while the transceiver runs
  assign tok_gated = token_valid & s_q.ctrl.transceiver_enable;

  ep_decode u_ep_decode (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .token_valid(tok_gated),
    .token_in(token_in),
    .token_addr(token_addr),
    .ep_sel(ep_sel)
  );

  // Outputs
  assign sfr_rdata = s_q.rdata;
  assign rx_diff = s_q.diff;
  assign rx_dp = s_q.dp_lvl;
  assign rx_dm = s_q.dm_lvl;
  assign full_speed = s_q.ctrl.full_speed;
  assign xcvr_suspend = ~s_q.ctrl.transceiver_enable;
  assign dp_out = s_q.dp_drv;
  assign dm_out = s_q.dm_drv;
  assign dp_oe = s_q.drive;
  assign dm_oe = s_q.drive;
  assign pullup_dp_en = s_q.pu_dp;
  assign pullup_dm_en = s_q.pu_dm;

  // Write then read back of the control fields
  sequence seq_ctrl_write;
    sfr_req.wr && ctrl_hit && !sfr_req.rd;
  endsequence
  sequence seq_ctrl_read;
    sfr_req.rd && ctrl_hit && !sfr_req.wr;
  endsequence

  a_ctrl_readback: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_ctrl_write ##1 seq_ctrl_read |=> sfr_rdata[7:3] == $past(sfr_req.wdata[7:3], 2))
    else $error("Control fields did not read back");
  a_pullup_dplus: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.ctrl.pullup_enable && s_q.ctrl.full_speed && vbus_present
    |=> pullup_dp_en && !pullup_dm_en)
    else $error("Full speed pullup not on D+");
  a_pullup_dminus: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.ctrl.pullup_enable && !s_q.ctrl.full_speed && vbus_present
    |=> pullup_dm_en && !pullup_dp_en)
    else $error("Low speed pullup not on D-");
  a_pullup_vbus: assert property (@(posedge mclk) disable iff (sys_rst)
    !vbus_present |=> !pullup_dp_en && !pullup_dm_en)
    else $error("Pullup on without bus power");
  a_pullup_detach: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_ctrl_write and !sfr_req.wdata[PULLUP_EN_BIT] |=> ##1 !pullup_dp_en && !pullup_dm_en)
    else $error("Pullup stayed after clear");
  a_test_diff_one: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.ctrl.transceiver_enable && s_q.ctrl.line_test_select == TEST_DIFF_ONE
    |=> dp_oe && dm_oe && dp_out && !dm_out)
    else $error("Differential one not forced");
  a_test_se_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.ctrl.transceiver_enable && s_q.ctrl.line_test_select == TEST_SE_ZERO
    |=> dp_oe && !dp_out && !dm_out)
    else $error("Single-ended zero not forced");
  a_no_unsolicited: assert property (@(posedge mclk) disable iff (sys_rst)
    !sie_tx.en && s_q.ctrl.line_test_select == TEST_NORMAL |=> !dp_oe && !dm_oe)
    else $error("Line driven without engine request");
  a_suspend_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    xcvr_suspend |=> !dp_oe && !rx_diff)
    else $error("Suspended transceiver active");
  a_level_report: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_ctrl_read |=> sfr_rdata[DPLUS_BIT] == $past(rx_dp) && sfr_rdata[DMINUS_BIT] == $past(rx_dm))
    else $error("Line levels misreported");
  a_test_diff_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.ctrl.transceiver_enable && s_q.ctrl.line_test_select == TEST_DIFF_ZERO
    |=> dp_oe && dm_oe && !dp_out && dm_out)
    else $error("Differential zero not forced");
  a_engine_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.ctrl.transceiver_enable && s_q.ctrl.line_test_select == TEST_NORMAL && sie_tx.en
    |=> dp_oe && dp_out == $past(sie_tx.dp) && dm_out == $past(sie_tx.dm))
    else $error("Engine drive not passed to pins");
  a_pin_copy: assert property (@(posedge mclk) disable iff (sys_rst)
    1'b1 |=> rx_dp == $past(dp_in) && rx_dm == $past(dm_in))
    else $error("Pin levels not copied");
  a_diff_one_seen: assert property (@(posedge mclk) disable iff (sys_rst)
    s_q.ctrl.transceiver_enable && dp_in && !dm_in |=> rx_diff)
    else $error("Differential one not reported");
endmodule // usb_xcvr_ctrl
`default_nettype wire

// ### logic/xcvr_pkg.sv
// Constants and types for the USB transceiver control block
// Summary of operation
// - Device acts only as peripheral, never host
// - 256-byte endpoint buffer; crystal-less clock recovery
// - Three pipes; EP1 IN 64, OUT 128
// - Endpoint zero is bidirectional, takes IN and OUT
// - Addresses 0x00 EP0, 0x81 EP1 IN, 0x01 OUT
// - Control holds transceiver, pullup enable, speed bits
// - Speed one: full speed, pullup on D+
// - Speed zero: low speed, pullup on D-
// - Pullup connects only while bus power present
// - Test field forces line states per code while transceiver enabled
`default_nettype none
package xcvr_pkg;
  // Register placement and reset
  localparam logic [7:0] XCVR_CTRL_ADDR = 8'hD7;
  localparam logic [7:0] XCVR_CTRL_RESET = 8'h00;
  // Field positions
  localparam int PULLUP_EN_BIT = 7;
  localparam int XCVR_EN_BIT = 6;
  localparam int SPEED_BIT = 5;
  localparam int TEST_HI_BIT = 4;
  localparam int TEST_LO_BIT = 3;
  localparam int DIFF_RX_BIT = 2;
  localparam int DPLUS_BIT = 1;
  localparam int DMINUS_BIT = 0;
  // Line test codes
  localparam logic [1:0] TEST_NORMAL = 2'h0;
  localparam logic [1:0] TEST_DIFF_ONE = 2'h1;
  localparam logic [1:0] TEST_DIFF_ZERO = 2'h2;
  localparam logic [1:0] TEST_SE_ZERO = 2'h3;
  // Endpoint protocol addresses
  localparam logic [7:0] EP0_ADDR = 8'h00;
  localparam logic [7:0] EP1_IN_ADDR = 8'h81;
  localparam logic [7:0] EP1_OUT_ADDR = 8'h01;
  // Endpoint buffer map inside the shared buffer block
  localparam logic [8:0] BUF_TOTAL_BYTES = 9'h100;
  localparam logic [8:0] EP1_IN_BYTES = 9'h040;
  localparam logic [8:0] EP1_OUT_BYTES = 9'h080;
  localparam logic [8:0] EP0_BYTES = 9'h040;
  localparam logic [7:0] EP0_BASE = 8'h00;
  localparam logic [7:0] EP1_IN_BASE = 8'h40;
  localparam logic [7:0] EP1_OUT_BASE = 8'h80;

  typedef enum logic [1:0] {PIPE_NONE, PIPE_EP0, PIPE_EP1_IN, PIPE_EP1_OUT} pipe_t;

  // Software-writable control fields
  typedef struct packed {
    logic pullup_enable;
    logic transceiver_enable;
    logic full_speed;
    logic [1:0] line_test_select;
  } xcvr_ctrl_t;

  // Processor special-function register access
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;

  // Transmit request from the serial engine
  typedef struct packed {
    logic en;
    logic dp;
    logic dm;
  } sie_tx_t;

  // Endpoint lookup answer
  typedef struct packed {
    logic hit;
    pipe_t pipe;
    logic [7:0] base;
    logic [8:0] size;
  } ep_sel_t;
endpackage
`default_nettype wire

// ### logic/ep_decode.sv
// Endpoint address decoder mapping tokens to pipes and buffers
`timescale 1ns/10ps
`default_nettype none
module ep_decode (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Token from the serial engine
  input wire logic token_valid,
  input wire logic token_in,
  input wire logic [7:0] token_addr,
  // Selected pipe
  output xcvr_pkg::ep_sel_t ep_sel
);
  import xcvr_pkg::*;

  typedef struct packed {
    ep_sel_t sel;
  } dec_state_t;

  dec_state_t s_q;
  dec_state_t s_d;

  // Lookup of the fixed endpoint map
  always_comb begin
    s_d = s_q;
    if (token_valid) begin
      s_d.sel = '{hit: 1'b0, pipe: PIPE_NONE, base: 8'h00, size: 9'h000};
      if (token_addr == EP0_ADDR) begin
        s_d.sel = '{hit: 1'b1, pipe: PIPE_EP0, base: EP0_BASE, size: EP0_BYTES};
      end else if (token_in && token_addr == EP1_IN_ADDR) begin
        s_d.sel = '{hit: 1'b1, pipe: PIPE_EP1_IN, base: EP1_IN_BASE, size: EP1_IN_BYTES};
      end else if (!token_in && token_addr == EP1_OUT_ADDR) begin
        s_d.sel = '{hit: 1'b1, pipe: PIPE_EP1_OUT, base: EP1_OUT_BASE, size: EP1_OUT_BYTES};
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '{sel: '{hit: 1'b0, pipe: PIPE_NONE, base: 8'h00, size: 9'h000}};
    end else begin
      s_q <= s_d;
    end
  end

  assign ep_sel = s_q.sel;

  a_ep1_in_map: assert property (@(posedge mclk) disable iff (sys_rst)
    token_valid && token_in && token_addr == EP1_IN_ADDR |=> ep_sel.pipe == PIPE_EP1_IN)
    else $error("EP1 IN address not mapped");
  a_ep0_both_dirs: assert property (@(posedge mclk) disable iff (sys_rst)
    token_valid && token_addr == EP0_ADDR |=> ep_sel.hit && ep_sel.pipe == PIPE_EP0)
    else $error("EP0 token missed");
  a_ep_unknown_miss: assert property (@(posedge mclk) disable iff (sys_rst)
    token_valid && token_addr != EP0_ADDR && token_addr != EP1_IN_ADDR
    && token_addr != EP1_OUT_ADDR |=> !ep_sel.hit)
    else $error("Unmapped endpoint accepted");
  a_buf_in_range: assert property (@(posedge mclk) disable iff (sys_rst)
    ep_sel.hit |-> ({1'b0, ep_sel.base} + ep_sel.size) <= BUF_TOTAL_BYTES)
    else $error("Pipe buffer overruns block");
endmodule // ep_decode
`default_nettype wire

// ### verif/usb_host_model.sv
// Host end of the cable: host line drive and line pulldowns
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
  // Device pin drive and pullups
  input wire logic dp_out,
  input wire logic dp_oe,
  input wire logic dm_out,
  input wire logic dm_oe,
  input wire logic pullup_dp_en,
  input wire logic pullup_dm_en,
  // Host drive requested by the bench
  input wire logic host_en,
  input wire logic host_dp,
  input wire logic host_dm,
  // Resolved line levels
  output logic dp_line,
  output logic dm_line
);
  // Device drive wins, then host drive, then pullup against host pulldown
  always_comb begin
    dp_line = dp_oe ? dp_out : (host_en ? host_dp : pullup_dp_en);
    dm_line = dm_oe ? dm_out : (host_en ? host_dm : pullup_dm_en);
  end
endmodule // usb_host_model
`default_nettype wire

// ### verif/usb_xcvr_ctrl_tb.sv
// Self-checking bench for the transceiver control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module usb_xcvr_ctrl_tb;
  import xcvr_pkg::*;
  logic mclk, sys_rst, vbus, tok_v, tok_in, host_en, host_dp, host_dm;
  logic [7:0] tok_a, sfr_rdata;
  sfr_req_t req;
  sie_tx_t sie;
  ep_sel_t ep_sel;
  logic rx_diff, rx_dp, rx_dm, full_speed, xcvr_suspend, dp_line, dm_line;
  logic dp_out, dp_oe, dm_out, dm_oe, pu_dp, pu_dm;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic tk_in[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] tk_ad[6] = '{8'h00, 8'h00, 8'h81, 8'h01, 8'h81, 8'h01};
  ep_sel_t tk_e[6] = '{'{1'b1, PIPE_EP0, 8'h00, 9'h040}, '{1'b1, PIPE_EP0, 8'h00, 9'h040},
    '{1'b1, PIPE_EP1_IN, 8'h40, 9'h040}, '{1'b1, PIPE_EP1_OUT, 8'h80, 9'h080},
    '{1'b0, PIPE_NONE, 8'h00, 9'h000}, '{1'b0, PIPE_NONE, 8'h00, 9'h000}};

  usb_xcvr_ctrl uut (.mclk(mclk), .sys_rst(sys_rst), .sfr_req(req), .sfr_rdata(sfr_rdata),
    .sie_tx(sie), .token_valid(tok_v), .token_in(tok_in), .token_addr(tok_a),
    .ep_sel(ep_sel), .rx_diff(rx_diff), .rx_dp(rx_dp), .rx_dm(rx_dm),
    .full_speed(full_speed), .xcvr_suspend(xcvr_suspend), .vbus_present(vbus),
    .dp_in(dp_line), .dp_out(dp_out), .dp_oe(dp_oe), .dm_in(dm_line), .dm_out(dm_out),
    .dm_oe(dm_oe), .pullup_dp_en(pu_dp), .pullup_dm_en(pu_dm));
  usb_host_model host (.dp_out(dp_out), .dp_oe(dp_oe), .dm_out(dm_out), .dm_oe(dm_oe),
    .pullup_dp_en(pu_dp), .pullup_dm_en(pu_dm), .host_en(host_en), .host_dp(host_dp),
    .host_dm(host_dm), .dp_line(dp_line), .dm_line(dm_line));

  // Clock at 200 MHz, running from time zero
  always #2.5 mclk = ~mclk;

  // Register write, then let pins and readback settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge mclk);
    req.wr = 1'b0;
    repeat (3) @(negedge mclk);
  endtask

  // Register read, checked on the falling edge just after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge mclk);
    req.rd = 1'b0;
    `CHK("sfr_rdata", e, sfr_rdata)
  endtask

  // Write, then read in the very next cycle
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(negedge mclk);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge mclk);
    req.wr = 1'b0;
    req.rd = 1'b1;
    @(negedge mclk);
    req.rd = 1'b0;
    `CHK("sfr_rdata b2b", e, sfr_rdata)
  endtask

  // One token pulse
  task automatic tok(input logic i, input logic [7:0] a);
    @(negedge mclk);
    tok_v = 1'b1;
    tok_in = i;
    tok_a = a;
    @(negedge mclk);
    tok_v = 1'b0;
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, well above the length of the sequence
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    req = '0;
    sie = '0;
    tok_v = 1'b0;
    tok_in = 1'b0;
    tok_a = 8'h00;
    vbus = 1'b1;
    host_en = 1'b0;
    host_dp = 1'b0;
    host_dm = 1'b0;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    `CHK("xcvr_suspend", 1'b1, xcvr_suspend)
    `CHK("pullups", 2'h0, {pu_dp, pu_dm})
    `CHK("ep_sel", 20'h00000, ep_sel)
    rd(8'hD7, 8'h00);
    wr(8'h55, 8'hE0);
    rd(8'h55, 8'h00);
    rd(8'hD7, 8'h00);
    // Full speed puts the pullup on D+, clock already running
    wr(8'hD7, 8'hE0);
    `CHK("pullup d+ d-", 2'h2, {pu_dp, pu_dm})
    `CHK("full_speed", 1'b1, full_speed)
    `CHK("xcvr_suspend", 1'b0, xcvr_suspend)
    rd(8'hD7, 8'hE6);
    `CHK("rx diff dp dm", 3'h6, {rx_diff, rx_dp, rx_dm})
    @(negedge mclk);
    vbus = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK("pullup no vbus", 2'h0, {pu_dp, pu_dm})
    vbus = 1'b1;
    wr(8'hD7, 8'hC0);
    `CHK("pullup d+ d-", 2'h1, {pu_dp, pu_dm})
    `CHK("full_speed", 1'b0, full_speed)
    rd(8'hD7, 8'hC1);
    wr(8'hD7, 8'h40);
    `CHK("pullup off", 2'h0, {pu_dp, pu_dm})
    // Forced line states for each test code
    for (int c = 1; c < 4; c++) begin
      wr(8'hD7, 8'h40 | 8'(c << 3));
      `CHK("forced d+ d- oe", {c == 1, c == 2, 2'h3}, {dp_out, dm_out, dp_oe, dm_oe})
      rd(8'hD7, 8'h40 | 8'(c << 3) | ((c == 1) ? 8'h06 : 8'((c == 2) ? 1 : 0)));
    end
    wr(8'hD7, 8'h40);
    sie = '{en: 1'b1, dp: 1'b0, dm: 1'b1};
    repeat (2) @(negedge mclk);
    `CHK("engine drive", 4'h7, {dp_out, dm_out, dp_oe, dm_oe})
    sie = '0;
    // Disabled transceiver ignores test code and receiver state
    wr(8'hD7, 8'h18);
    `CHK("drive off", 2'h0, {dp_oe, dm_oe})
    `CHK("xcvr_suspend", 1'b1, xcvr_suspend)
    host_en = 1'b1;
    host_dp = 1'b1;
    rd(8'hD7, 8'h1A);
    `CHK("rx diff dp dm", 3'h2, {rx_diff, rx_dp, rx_dm})
    wr(8'hD7, 8'h40);
    rd(8'hD7, 8'h46);
    wrrd(8'hD7, 8'h60, 8'h66);
    host_en = 1'b0;
    // Token decode over every endpoint address and direction
    for (int k = 0; k < 6; k++) begin
      tok(tk_in[k], tk_ad[k]);
      `CHK("hit pipe", {tk_e[k].hit, tk_e[k].pipe}, {ep_sel.hit, ep_sel.pipe})
      if (tk_e[k].hit) `CHK("base size", {tk_e[k].base, tk_e[k].size}, {ep_sel.base, ep_sel.size})
    end
    tok(1'b1, 8'h81);
    wr(8'hD7, 8'h00);
    tok(1'b0, 8'h00);
    `CHK("held pipe", PIPE_EP1_IN, ep_sel.pipe)
    // Reset in mid-run clears the map and the control fields
    sys_rst = 1'b1;
    @(negedge mclk);
    sys_rst = 1'b0;
    `CHK("ep_sel rst", 20'h00000, ep_sel)
    `CHK("xcvr_suspend rst", 1'b1, xcvr_suspend)
    rd(8'hD7, 8'h00);
    finish_test();
  end
endmodule // usb_xcvr_ctrl_tb
`default_nettype wire
